// ===== hw/ptd_decoder.sv
// Purpose: Parse proprietary template byte stream into fields
// Assumes: One byte taken on each cycle with in_valid high
// Notes:   A new template header clears all results
`timescale 1ns/10ps
`default_nettype none
module ptd_decoder
  import ptd_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Byte stream
  input  wire logic                 in_valid,
  input  wire logic [7:0]           in_data,
  output logic                      in_ready,
  // File context
  input  wire ptd_file_kind_t       file_kind,
  // Decoded results
  output ptd_char_t                 chr,
  output ptd_power_t [NUM_INST-1:0] power,
  output logic [2:0]                power_cnt,
  output logic [NUM_INST-1:0] [7:0] min_clk,
  output logic [2:0]                min_clk_cnt,
  output logic [9:0]                seen,
  output ptd_status_t               status
);

  ptd_state_t                 state_ff;
  logic [7:0]                 rem_ff;
  logic [7:0]                 olen_ff;
  logic [7:0]                 vidx_ff;
  logic [7:0]                 tag_ff;
  logic [7:0]                 last_tag_ff;
  logic [9:0]                 seen_ff;
  ptd_char_t                  chr_ff;
  ptd_power_t [NUM_INST-1:0]  pw_ff;
  logic [2:0]                 pw_cnt_ff;
  logic [NUM_INST-1:0] [7:0]  mc_ff;
  logic [2:0]                 mc_cnt_ff;
  ptd_status_t                st_ff;
  logic                       start;
  logic                       tag_def;
  logic [3:0]                 tag_ix;
  logic [7:0]                 rem_dec;
  logic                       obj_last;
  logic                       fin;
  logic                       ovr;
  logic                       len_ok;
  logic                       pres_bad;

  // Stream is always accepted
  assign in_ready = 1'b1;

  // Byte decode helpers
  assign start    = in_valid && state_ff == ST_IDLE && in_data == TAG_TEMPLATE;
  assign tag_def  = in_data >= TAG_CHAR && in_data <= TAG_LAST;
  assign tag_ix   = in_data[3:0];
  assign rem_dec  = rem_ff - 8'h01;
  assign obj_last = in_valid && state_ff == ST_OVAL && vidx_ff == olen_ff - 8'h01;
  assign len_ok   = (tag_ff == TAG_CHAR && olen_ff == LEN_CHAR) ||
                    (tag_ff == TAG_POWER && olen_ff == LEN_POWER) ||
                    (tag_ff == TAG_MINCLK && olen_ff == LEN_MINCLK);

  // Overrun: tag byte is the last one, or length byte asks for more bytes than are left
  assign ovr = in_valid && ((state_ff == ST_OTAG && rem_ff == 8'h01) ||
                            (state_ff == ST_OLEN && in_data > rem_dec));

  // Template ends on an object boundary
  assign fin = in_valid && ((state_ff == ST_TLEN && in_data == 8'h00) ||
                            (state_ff == ST_OLEN && in_data == 8'h00 && rem_dec == 8'h00) ||
                            (obj_last && rem_ff == 8'h01));

  // Presence checks for the file kind, judged at the end
  assign pres_bad = (file_kind == FK_ROOT_MASTER_FILE && !seen_ff[TIX_CHAR]) ||
                    (file_kind == FK_ROOT_MASTER_FILE && !seen_ff[TIX_SYSCMD]) ||
                    (file_kind != FK_APPLICATION_DIR && seen_ff[TIX_POWER]) ||
                    (file_kind != FK_ELEMENTARY_BERTLV && seen_ff[TIX_MAXSIZE]);

  // Parser state walk
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else if (in_valid)
    begin
      case (state_ff)
        ST_IDLE: if (in_data == TAG_TEMPLATE) state_ff <= ST_TLEN;
        ST_TLEN: state_ff <= (in_data == 8'h00) ? ST_IDLE : ST_OTAG;
        ST_OTAG: state_ff <= ovr ? ST_IDLE : ST_OLEN;
        ST_OLEN: state_ff <= (ovr || fin) ? ST_IDLE :
                             (in_data == 8'h00) ? ST_OTAG : ST_OVAL;
        ST_OVAL: if (obj_last) state_ff <= fin ? ST_IDLE : ST_OTAG;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Byte counters and current object; private tags skip the same way
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rem_ff  <= 8'h00;
      olen_ff <= 8'h00;
      vidx_ff <= 8'h00;
      tag_ff  <= 8'h00;
    end
    else if (in_valid)
    begin
      if (state_ff == ST_TLEN)
        rem_ff <= in_data;
      else if (state_ff != ST_IDLE)
        rem_ff <= rem_dec;
      if (state_ff == ST_OTAG)
        tag_ff <= in_data;
      if (state_ff == ST_OLEN)
      begin
        olen_ff <= in_data;
        vidx_ff <= 8'h00;
      end
      else if (state_ff == ST_OVAL)
        vidx_ff <= vidx_ff + 8'h01;
    end
  end

  // Tag bookkeeping: which defined tags appeared, and grouping
  always_ff @(posedge mclk)
  begin
    if (sys_rst || start)
    begin
      seen_ff     <= RST_SEEN;
      last_tag_ff <= 8'h00;
    end
    else if (in_valid && state_ff == ST_OTAG)
    begin
      last_tag_ff <= in_data;
      if (tag_def)
        seen_ff[tag_ix] <= 1'b1;
    end
  end

  // Card characteristics byte
  always_ff @(posedge mclk)
  begin
    if (sys_rst || start)
      chr_ff <= '0;
    else if (in_valid && state_ff == ST_OVAL && tag_ff == TAG_CHAR && len_ok)
    begin
      chr_ff.present    <= 1'b1;
      chr_ff.stop_any   <= in_data[CHB_STOP_ANY];
      chr_ff.pref_level <= {in_data[CHB_PREF_LO], in_data[CHB_PREF_HI]};
      chr_ff.stop_hi_ok <= in_data[CHB_STOP_ANY] | in_data[CHB_PREF_HI];
      chr_ff.stop_lo_ok <= in_data[CHB_STOP_ANY] | in_data[CHB_PREF_LO];
      chr_ff.class_a    <= in_data[CHB_CLASS_A];
      chr_ff.class_b    <= in_data[CHB_CLASS_B];
      chr_ff.class_c    <= in_data[CHB_CLASS_C];
      chr_ff.rsv_err    <= |(in_data & CHB_RSV_MASK);
    end
  end

  // Power and min-clock instances, one slot each, filled in arrival order
  generate
    for (genvar gi = 0; gi < NUM_INST; gi++)
    begin : g_pw
      always_ff @(posedge mclk)
      begin
        if (sys_rst || start)
          pw_ff[gi] <= '0;
        else if (in_valid && state_ff == ST_OVAL && tag_ff == TAG_POWER && len_ok &&
                 pw_cnt_ff == 3'(gi))
        begin
          case (vidx_ff)
            8'h00: pw_ff[gi].vclass <= in_data;
            8'h01:
            begin
              pw_ff[gi].current    <= in_data[5:0] & CUR_MASK[5:0];
              pw_ff[gi].cur_usable <= in_data[7:6] == 2'b00 &&
                                      in_data[5:0] >= CUR_MIN && in_data[5:0] <= CUR_MAX;
            end
            8'h02:
            begin
              pw_ff[gi].ref_freq   <= in_data;
              pw_ff[gi].freq_given <= in_data != FREQ_NONE && in_data >= FREQ_MIN;
            end
            default: pw_ff[gi].vclass <= pw_ff[gi].vclass;
          endcase
        end
      end
      always_ff @(posedge mclk)
      begin
        if (sys_rst || start)
          mc_ff[gi] <= 8'h00;
        else if (in_valid && state_ff == ST_OVAL && tag_ff == TAG_MINCLK && len_ok &&
                 mc_cnt_ff == 3'(gi))
          mc_ff[gi] <= in_data;
      end
    end
  endgenerate

  // Instance counters advance at the last byte of each well-formed power or min-clock object, and hold at INST_FULL
  always_ff @(posedge mclk)
  begin
    if (sys_rst || start)
    begin
      pw_cnt_ff <= RST_CNT;
      mc_cnt_ff <= RST_CNT;
    end
    else if (obj_last && len_ok)
    begin
      if (tag_ff == TAG_POWER && pw_cnt_ff != INST_FULL)
        pw_cnt_ff <= pw_cnt_ff + 3'h1;
      if (tag_ff == TAG_MINCLK && mc_cnt_ff != INST_FULL)
        mc_cnt_ff <= mc_cnt_ff + 3'h1;
    end
  end

  // Status flags; errors stick until the next template header
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st_ff <= '0;
    else
    begin
      st_ff.done <= fin;
      st_ff.busy <= (state_ff != ST_IDLE || start) && !fin && !ovr;
      if (start)
        {st_ff.len_err, st_ff.fmt_err, st_ff.group_err, st_ff.presence_err, st_ff.inst_ovf} <= 5'h00;
      else
      begin
        if (ovr)
          st_ff.len_err <= 1'b1;
        if (in_valid && state_ff == ST_OLEN && !ovr &&
            ((tag_ff == TAG_CHAR && in_data != LEN_CHAR) ||
             (tag_ff == TAG_POWER && in_data != LEN_POWER) ||
             (tag_ff == TAG_MINCLK && in_data != LEN_MINCLK)))
          st_ff.fmt_err <= 1'b1;
        if (in_valid && state_ff == ST_OTAG && tag_def &&
            in_data != last_tag_ff && seen_ff[tag_ix])
          st_ff.group_err <= 1'b1;
        if (fin && pres_bad)
          st_ff.presence_err <= 1'b1;
        if (obj_last && len_ok && ((tag_ff == TAG_POWER && pw_cnt_ff == INST_FULL) ||
            (tag_ff == TAG_MINCLK && mc_cnt_ff == INST_FULL)))
          st_ff.inst_ovf <= 1'b1;
      end
    end
  end

  // Outputs from flip-flops
  assign chr         = chr_ff;
  assign power       = pw_ff;
  assign power_cnt   = pw_cnt_ff;
  assign min_clk     = mc_ff;
  assign min_clk_cnt = mc_cnt_ff;
  assign seen        = seen_ff;
  assign status      = st_ff;

  // Checks
  property p_hdr;
    @(posedge mclk) disable iff (sys_rst)
    start |=> (state_ff == ST_TLEN) and (in_valid |=> rem_ff == $past(in_data));
  endproperty
  a_hdr: assert property (p_hdr) else $error("header not followed by length");

  property p_priv;
    @(posedge mclk) disable iff (sys_rst)
    in_valid && state_ff == ST_OTAG && in_data[7:6] == PRIV_CLASS && !ovr
      |=> $stable(st_ff.fmt_err) && state_ff == ST_OLEN;
  endproperty
  a_priv: assert property (p_priv) else $error("private tag not skipped");

  property p_group;
    @(posedge mclk) disable iff (sys_rst)
    in_valid && state_ff == ST_OTAG && tag_def && in_data != last_tag_ff && seen_ff[tag_ix]
      |=> st_ff.group_err;
  endproperty
  a_group: assert property (p_group) else $error("split tag group missed");

  property p_char;
    @(posedge mclk) disable iff (sys_rst)
    in_valid && state_ff == ST_OVAL && tag_ff == TAG_CHAR && olen_ff == LEN_CHAR
      |=> chr.present && chr.stop_any == $past(in_data[CHB_STOP_ANY]) &&
          chr.pref_level == $past({in_data[CHB_PREF_LO], in_data[CHB_PREF_HI]});
  endproperty
  a_char: assert property (p_char) else $error("clock stop field wrong");

  property p_class;
    @(posedge mclk) disable iff (sys_rst)
    in_valid && state_ff == ST_OVAL && tag_ff == TAG_CHAR && olen_ff == LEN_CHAR
      |=> {chr.class_c, chr.class_b, chr.class_a} == $past(in_data[6:4]) &&
          chr.rsv_err == $past(|(in_data & CHB_RSV_MASK));
  endproperty
  a_class: assert property (p_class) else $error("class or reserved bits wrong");

  property p_pw_cnt;
    @(posedge mclk) disable iff (sys_rst)
    obj_last && tag_ff == TAG_POWER && olen_ff == LEN_POWER && pw_cnt_ff < INST_FULL
      |=> pw_cnt_ff == $past(pw_cnt_ff) + 3'h1;
  endproperty
  a_pw_cnt: assert property (p_pw_cnt) else $error("power instance not counted");

  property p_freq;
    @(posedge mclk) disable iff (sys_rst)
    obj_last && tag_ff == TAG_POWER && len_ok && in_data == FREQ_NONE && pw_cnt_ff < INST_FULL
      |=> !power[$past(pw_cnt_ff[1:0])].freq_given;
  endproperty
  a_freq: assert property (p_freq) else $error("absent frequency reported");

  property p_done;
    @(posedge mclk) disable iff (sys_rst)
    fin |=> status.done ##1 !status.done;
  endproperty
  a_done: assert property (p_done) else $error("done not one cycle");

  property p_ovr;
    @(posedge mclk) disable iff (sys_rst)
    in_valid && state_ff == ST_OLEN && in_data > rem_dec
      |=> status.len_err && state_ff == ST_IDLE && !status.done;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_root;
    @(posedge mclk) disable iff (sys_rst)
    fin && file_kind == FK_ROOT_MASTER_FILE && !seen_ff[TIX_CHAR] |=> status.presence_err;
  endproperty
  a_root: assert property (p_root) else $error("missing characteristics");

  // Main scenarios
  property p_cv_done;
    @(posedge mclk) disable iff (sys_rst) status.done && !status.len_err;
  endproperty
  c_done: cover property (p_cv_done);

  property p_cv_two_pw;
    @(posedge mclk) disable iff (sys_rst) power_cnt == 3'h2;
  endproperty
  c_two_pw: cover property (p_cv_two_pw);

  property p_cv_ovr;
    @(posedge mclk) disable iff (sys_rst) ovr;
  endproperty
  c_ovr: cover property (p_cv_ovr);

endmodule : ptd_decoder
`default_nettype wire

// ===== hw/ptd_pkg.sv
// Purpose: Shared types and constants of the template decoder
// Assumes: Single-byte tags inside the template
// Notes:   Value bytes count from b1 = bit 0
package ptd_pkg;
  // Tag values
  localparam logic [7:0] TAG_TEMPLATE = 8'ha5;
  localparam logic [7:0] TAG_CHAR     = 8'h80;
  localparam logic [7:0] TAG_POWER    = 8'h81;
  localparam logic [7:0] TAG_MINCLK   = 8'h82;
  localparam logic [7:0] TAG_LAST     = 8'h89;
  localparam logic [3:0] TIX_CHAR     = 4'h0;
  localparam logic [3:0] TIX_POWER    = 4'h1;
  localparam logic [3:0] TIX_MAXSIZE  = 4'h6;
  localparam logic [3:0] TIX_SYSCMD   = 4'h7;
  localparam logic [1:0] PRIV_CLASS   = 2'h3;
  // Object lengths
  localparam logic [7:0] LEN_CHAR     = 8'h01;
  localparam logic [7:0] LEN_POWER    = 8'h03;
  localparam logic [7:0] LEN_MINCLK   = 8'h01;
  // Characteristics byte fields
  localparam int         CHB_STOP_ANY = 0;
  localparam int         CHB_PREF_HI  = 2;
  localparam int         CHB_PREF_LO  = 3;
  localparam int         CHB_CLASS_A  = 4;
  localparam int         CHB_CLASS_B  = 5;
  localparam int         CHB_CLASS_C  = 6;
  localparam logic [7:0] CHB_RSV_MASK = 8'h82;
  // Power object fields
  localparam logic [7:0] CUR_MASK     = 8'h3f;
  localparam logic [5:0] CUR_MIN      = 6'h01;
  localparam logic [5:0] CUR_MAX      = 6'h3c;
  localparam logic [7:0] FREQ_MIN     = 8'h0a;
  localparam logic [7:0] FREQ_NONE    = 8'hff;
  // Instance storage
  localparam int         NUM_INST     = 4;
  localparam logic [2:0] INST_FULL    = 3'h4;
  localparam logic [2:0] RST_CNT      = 3'h0;
  localparam logic [9:0] RST_SEEN     = 10'h000;
  // Parser states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TLEN = 5'h02,
    ST_OTAG = 5'h04,
    ST_OLEN = 5'h08,
    ST_OVAL = 5'h10
  } ptd_state_t;
  // Kind of file whose template is parsed
  typedef enum logic [2:0] {
    FK_ROOT_MASTER_FILE  = 3'h0,
    FK_APPLICATION_DIR   = 3'h1,
    FK_DIRECTORY_FILE    = 3'h2,
    FK_ELEMENTARY_FILE   = 3'h3,
    FK_ELEMENTARY_BERTLV = 3'h4
  } ptd_file_kind_t;
  // Decoded card characteristics
  typedef struct packed {
    logic       present;
    logic       stop_any;
    logic [1:0] pref_level;
    logic       stop_hi_ok;
    logic       stop_lo_ok;
    logic       class_a;
    logic       class_b;
    logic       class_c;
    logic       rsv_err;
  } ptd_char_t;
  // One power-consumption instance
  typedef struct packed {
    logic [7:0] vclass;
    logic [5:0] current;
    logic       cur_usable;
    logic [7:0] ref_freq;
    logic       freq_given;
  } ptd_power_t;
  // Parse status
  typedef struct packed {
    logic done;
    logic busy;
    logic len_err;
    logic fmt_err;
    logic group_err;
    logic presence_err;
    logic inst_ovf;
  } ptd_status_t;
endpackage : ptd_pkg

// ===== tb/ptd_byte_source.sv
// Purpose: Card-side byte source feeding the template decoder
// Assumes: Bytes launched at the falling edge of mclk
// Notes:   Data line shows the inverted last byte between bytes
`timescale 1ns/10ps
`default_nettype none
module ptd_byte_source
(
  // Clock
  input  wire logic       mclk,
  // Byte stream towards the decoder
  output var  logic       in_valid,
  output var  logic [7:0] in_data
);
  // Idle line at time zero
  initial
  begin
    in_valid = 1'b0;
    in_data  = 8'h00;
  end

  // Stream bytes in order, prompt or with gap cycles
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[i])
    begin
      @(negedge mclk);
      in_valid = 1'b1;
      in_data  = q[i];
      if (gap > 0)
      begin
        @(negedge mclk);
        in_valid = 1'b0;
        in_data  = ~q[i];
        repeat (gap - 1) @(negedge mclk);
      end
    end
    @(negedge mclk);
    in_valid = 1'b0;
    in_data  = ~in_data;
  endtask : send
endmodule : ptd_byte_source
`default_nettype wire

// ===== tb/test_proprietary_template_tlv_decoder.sv
// Purpose: Self-checking bench of the template decoder
// Assumes: Inputs change at the falling edge of mclk
// Notes:   Table rows first, awkward cases by hand after
`timescale 1ns/10ps
`default_nettype none
module test_proprietary_template_tlv_decoder;
  import ptd_pkg::*;
  typedef struct {
    int             n;
    logic [255:0]   b;
    ptd_file_kind_t fk;
    logic [7:0]     cb;
    logic           hc;
    ptd_power_t     p0;
    logic [2:0]     pc;
    logic [9:0]     sn;
    logic [3:0]     er;
  } ptd_row_t;
  logic                      mclk;
  logic                      sys_rst;
  logic                      in_valid;
  logic [7:0]                in_data;
  logic                      in_ready;
  ptd_file_kind_t            file_kind;
  ptd_char_t                 chr;
  ptd_power_t [NUM_INST-1:0] power;
  logic [2:0]                power_cnt;
  logic [NUM_INST-1:0] [7:0] min_clk;
  logic [2:0]                min_clk_cnt;
  logic [9:0]                seen;
  ptd_status_t               status;
  int                        n_fail;
  int                        checks_done;
  int                        n_done;
  int                        d0;
  ptd_row_t                  rows[$];
  logic [7:0]                q[$];
  logic [7:0]                codes[13] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h05, 8'h09, 8'h0d,
                                           8'h0c, 8'h10, 8'h20, 8'h40, 8'h70, 8'h82};
  logic [23:0]               pws[5] = '{24'h013c0a, 24'h0200ff, 24'h04ff09, 24'h013dfe,
                                        24'h01010a};

  // Clock, 5 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ptd_byte_source ptd_byte_source_inst (.mclk(mclk), .in_valid(in_valid), .in_data(in_data));

  ptd_decoder ptd_decoder_inst (
    .mclk(mclk), .sys_rst(sys_rst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .file_kind(file_kind), .chr(chr), .power(power),
    .power_cnt(power_cnt), .min_clk(min_clk), .min_clk_cnt(min_clk_cnt), .seen(seen),
    .status(status));

  // Count completion pulses
  always @(posedge mclk)
    if (status.done === 1'b1)
      n_done <= n_done + 1;

  // Expected characteristics fields from the byte
  function automatic ptd_char_t chr_of(input logic [7:0] b);
    chr_of = {1'b1, b[0], b[3], b[2], b[0] | b[2], b[0] | b[3], b[4], b[5], b[6],
              |(b & 8'h82)};
  endfunction : chr_of

  // Expected power instance from its three bytes
  function automatic ptd_power_t pw_of(input logic [23:0] w);
    pw_of = {w[23:16], w[13:8], (w[15:14] == 2'b00 && w[13:8] >= 6'h01 && w[13:8] <= 6'h3c),
             w[7:0], (w[7:0] != 8'hff && w[7:0] >= 8'h0a)};
  endfunction : pw_of

  // Compare and count
  task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Print counts and verdict, end the run
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Table row builder
  task automatic add(input int n, input logic [255:0] b, input ptd_file_kind_t fk,
                     input logic [7:0] cb, input logic hc, input logic [23:0] pw,
                     input logic [2:0] pc, input logic [9:0] sn, input logic [3:0] er);
    rows.push_back('{n, b, fk, cb, hc, (pc != 3'h0) ? pw_of(pw) : '0, pc, sn, er});
  endtask : add

  // Send a byte queue for a file kind, let results settle
  task automatic xfer(input ptd_file_kind_t fk, input int gap);
    @(negedge mclk);
    file_kind = fk;
    d0 = n_done;
    ptd_byte_source_inst.send(q, gap);
    repeat (2) @(negedge mclk);
  endtask : xfer

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    n_done = 0;
    sys_rst = 1'b1;
    file_kind = FK_ROOT_MASTER_FILE;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk(in_ready, 1'b1, "ready at reset");
    chk({chr, power, power_cnt, min_clk, min_clk_cnt, seen, status}, '0, "reset outputs");
    sys_rst = 1'b0;
    foreach (codes[i])
      add(8, {8'ha5, 8'h06, 8'h80, 8'h01, codes[i], 24'h870101}, FK_ROOT_MASTER_FILE,
          codes[i], 1, 0, 0, 10'h081, 0);
    foreach (pws[i])
      add(7, {32'ha5058103, pws[i]}, FK_APPLICATION_DIR, 0, 0, pws[i], 1, 10'h002, 0);
    add(11, 88'ha5098103011020df02aabb, FK_APPLICATION_DIR, 0, 0, 24'h011020, 1, 10'h002, 0);
    add(5, 40'ha503800101, FK_ROOT_MASTER_FILE, 8'h01, 1, 0, 0, 10'h001, 4'h1);
    add(13, 104'ha50b8001018701008103011020, FK_ROOT_MASTER_FILE, 8'h01, 1, 24'h011020, 1,
        10'h083, 4'h1);
    add(6, 48'ha50486020010, FK_ELEMENTARY_FILE, 0, 0, 0, 0, 10'h040, 4'h1);
    add(6, 48'ha50486020010, FK_ELEMENTARY_BERTLV, 0, 0, 0, 0, 10'h040, 0);
    add(5, 40'ha503870101, FK_DIRECTORY_FILE, 0, 0, 0, 0, 10'h080, 0);
    add(5, 40'ha503870101, FK_ROOT_MASTER_FILE, 0, 0, 0, 0, 10'h080, 4'h1);
    add(4, 32'ha5028000, FK_ROOT_MASTER_FILE, 0, 0, 0, 0, 10'h001, 4'h5);
    add(6, 48'ha50481020110, FK_APPLICATION_DIR, 0, 0, 0, 0, 10'h002, 4'h4);
    add(13, 104'ha50b8201208103011020820130, FK_APPLICATION_DIR, 0, 0, 24'h011020, 1,
        10'h006, 4'h2);
    add(5, 40'ha503800231, FK_ROOT_MASTER_FILE, 0, 0, 0, 0, 10'h001, 4'h8);
    add(3, 24'ha501c5, FK_APPLICATION_DIR, 0, 0, 0, 0, 10'h000, 4'h8);
    add(2, 16'ha500, FK_APPLICATION_DIR, 0, 0, 0, 0, 10'h000, 0);
    add(25, 200'ha51780010183020010840101850200208701008801008901ff, FK_ROOT_MASTER_FILE,
        8'h01, 1, 0, 0, 10'h3b9, 0);
    // Table loop, gaps of zero to two cycles
    foreach (rows[r])
    begin
      q.delete();
      for (int i = 0; i < rows[r].n; i++)
        q.push_back(rows[r].b[8 * (rows[r].n - 1 - i) +: 8]);
      xfer(rows[r].fk, r % 3);
      chk(chr, rows[r].hc ? chr_of(rows[r].cb) : '0, "chr");
      chk(power[0], rows[r].p0, "power");
      chk(power_cnt, rows[r].pc, "power count");
      chk(seen, rows[r].sn, "seen");
      chk({status.len_err, status.fmt_err, status.group_err, status.presence_err}, rows[r].er,
          "errors");
      chk(n_done - d0, !rows[r].er[3], "done");
    end
    // Idle junk, then two templates back to back
    q = '{8'h80, 8'h11, 8'ha5, 8'h00, 8'ha5, 8'h05, 8'h81, 8'h03, 8'h01, 8'h10, 8'h20};
    xfer(FK_APPLICATION_DIR, 0);
    chk(n_done - d0, 2, "back to back done");
    chk(power[0], pw_of(24'h011020), "second template power");
    // Grouped repeats keep arrival order
    q = '{8'ha5, 8'h10, 8'h81, 8'h03, 8'h01, 8'h10, 8'h20, 8'h81, 8'h03, 8'h02, 8'h20, 8'hff,
          8'h82, 8'h01, 8'h30, 8'h82, 8'h01, 8'h40};
    xfer(FK_APPLICATION_DIR, 1);
    chk({power[1], power[0]}, {pw_of(24'h0220ff), pw_of(24'h011020)}, "order");
    chk({power_cnt, min_clk_cnt, status.group_err}, {3'h2, 3'h2, 1'b0}, "counts");
    chk(min_clk[1:0], {8'h40, 8'h30}, "min clock order");
    // Five power objects overflow the store
    q = '{8'ha5, 8'h19};
    for (int k = 0; k < 5; k++)
      q = {q, 8'h81, 8'h03, 8'(k), 8'(k + 1), 8'(8'h0a + k)};
    xfer(FK_APPLICATION_DIR, 0);
    chk({power_cnt, status.inst_ovf}, {3'h4, 1'b1}, "overflow");
    chk(power[3], pw_of(24'h03040d), "fourth kept");
    // Reset in mid-template, then an empty template
    q = '{8'ha5, 8'h05, 8'h81};
    xfer(FK_APPLICATION_DIR, 0);
    chk(status.busy, 1'b1, "busy mid template");
    sys_rst = 1'b1;
    @(negedge mclk);
    chk({power_cnt, seen, status}, '0, "mid reset");
    sys_rst = 1'b0;
    q = '{8'ha5, 8'h00};
    xfer(FK_APPLICATION_DIR, 0);
    chk({n_done - d0, status.len_err}, {32'd1, 1'b0}, "after reset");
    give_verdict();
  end
endmodule : test_proprietary_template_tlv_decoder
`default_nettype wire
